/* hw/stc_pkg.sv */
// Purpose: constants and types for the sixteen-bit timer core with byte-wise access
// Assumes: 8-bit register port, 100 MHz system clock, one timer instance
// Notes: register offsets are byte indices on the 8-bit port
// ============================================================
// Overview of operation
// - legacy mode: one timer, channels A and B
// - 16-bit data registers, 8-bit plain control registers
// - every request has a flag and mask bit
// - prescaler or pin clock; none stops counting
// - compares run always, drive waveform pins
// - compare match sets channel flag
// - edge on pin or comparator captures counter
// - top is fixed, compare A or capture
// - compare A top in modes B/F: no A output, buffered
// - bottom is zero, max is all ones
// - one shared high byte holding register
// - low byte write loads both bytes together
// - counter or capture low byte read copies high byte to holding
// - compare reads bypass the holding register
// - four-bit mode field, top two bits in B
// - force bits in C, which reads as zero
// - channel C has own flag and mask
// - counter write beats clear and count
// - code 1 direct, codes 2..5 divide 8..1024
// - codes 7/6 count pin rising/falling edges
package stc_pkg;
   // ============================================================
   // register map (byte offsets)
   localparam logic [4:0] STC_CTRL_A   = 5'h00;
   localparam logic [4:0] STC_CTRL_B   = 5'h01;
   localparam logic [4:0] STC_CTRL_C   = 5'h02;
   localparam logic [4:0] STC_CNT_L    = 5'h04;
   localparam logic [4:0] STC_CNT_H    = 5'h05;
   localparam logic [4:0] STC_CMPA_L   = 5'h06;
   localparam logic [4:0] STC_CMPA_H   = 5'h07;
   localparam logic [4:0] STC_CMPB_L   = 5'h08;
   localparam logic [4:0] STC_CMPB_H   = 5'h09;
   localparam logic [4:0] STC_CMPC_L   = 5'h0A;
   localparam logic [4:0] STC_CMPC_H   = 5'h0B;
   localparam logic [4:0] STC_CAP_L    = 5'h0C;
   localparam logic [4:0] STC_CAP_H    = 5'h0D;
   localparam logic [4:0] STC_FLAGS    = 5'h10;
   localparam logic [4:0] STC_MASK     = 5'h11;
   // ============================================================
   // field positions
   localparam int STC_FLG_OVF  = 0;
   localparam int STC_FLG_CMPA = 1;
   localparam int STC_FLG_CMPB = 2;
   localparam int STC_FLG_CMPC = 3;
   localparam int STC_FLG_CAP  = 4;
   localparam int STC_B_WGM3   = 4;
   localparam int STC_B_WGM2   = 3;
   localparam int STC_B_CAPEDGE = 6;
   localparam int STC_B_NOISE  = 7;
   localparam int STC_B_ACSEL  = 5;
   localparam int STC_C_FOCA   = 7;
   localparam int STC_C_FOCB   = 6;
   localparam int STC_C_FOCC   = 5;
   // ============================================================
   // reset values and constants
   localparam logic [7:0]  STC_CTRL_RST = 8'h00;
   localparam logic [15:0] STC_BOTTOM   = 16'h0000;
   localparam logic [15:0] STC_MAX      = 16'hFFFF;
   localparam logic [15:0] STC_TOP8     = 16'h00FF;
   localparam logic [15:0] STC_TOP9     = 16'h01FF;
   localparam logic [15:0] STC_TOP10    = 16'h03FF;
   localparam logic [9:0]  STC_PRE_MAX  = 10'h3FF;
   localparam int          STC_NOISE_LEN = 4;
   typedef enum logic [2:0] {
      STC_CS_OFF, STC_CS_DIV1, STC_CS_DIV8, STC_CS_DIV64,
      STC_CS_DIV256, STC_CS_DIV1024, STC_CS_EXT_FALL, STC_CS_EXT_RISE
   } stc_clksel_t;
   // register port request bundle
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } stc_bus_t;
endpackage : stc_pkg

/* hw/stc_timer.sv */
// Purpose: sixteen-bit timer core with shared high byte access path
// Assumes: all inputs synchronous to clk_i
// Notes: waveform pins toggle on match; detailed pwm shaping not modelled
//
// Design decisions made here: the register addresses and the plain strobed port.
module stc_timer
   import stc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       legacy_mode_i,
   input  wire logic [4:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       external_clock_pin_i,
   input  wire logic       capture_input_pin_i,
   input  wire logic       comparator_i,
   output logic            waveform_output_a_o,
   output logic            waveform_output_b_o,
   output logic            waveform_output_c_o,
   output logic            irq_o
);
   stc_bus_t bus;
   assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   // ============================================================
   // state
   logic [7:0]  ctrl_a_reg, ctrl_a_next, ctrl_b_reg, ctrl_b_next;
   logic [7:0]  hold_reg, hold_next, rdata_reg, rdata_next;
   logic [15:0] cnt_reg, cnt_next, cap_reg, cap_next;
   logic [15:0] cmp_reg [3], cmp_next [3], cmpbuf_reg [3], cmpbuf_next [3];
   logic [4:0]  flag_reg, flag_next, mask_reg, mask_next;
   logic [2:0]  wave_reg, wave_next;
   logic [9:0]  pre_reg, pre_next;
   logic [1:0]  ext_reg, ext_next;
   logic [STC_NOISE_LEN-1:0] capf_reg, capf_next;
   logic        capl_reg, capl_next;
   logic        irq_reg, irq_next;
   logic [3:0]  wgm;
   logic        tick, at_top, cap_trig, chan_ok [3], force_c [3], match [3];
   logic [15:0] top;
   stc_clksel_t cs;

   assign cs  = stc_clksel_t'(ctrl_b_reg[2:0]);
   assign wgm = {ctrl_b_reg[STC_B_WGM3], ctrl_b_reg[STC_B_WGM2], ctrl_a_reg[1:0]};

   // ============================================================
   // timer clock select
   always_comb begin
      unique case (cs)
         STC_CS_OFF:      tick = 1'b0;
         STC_CS_DIV1:     tick = 1'b1;
         STC_CS_DIV8:     tick = (pre_reg[2:0] == 3'h7);
         STC_CS_DIV64:    tick = (pre_reg[5:0] == 6'h3F);
         STC_CS_DIV256:   tick = (pre_reg[7:0] == 8'hFF);
         STC_CS_DIV1024:  tick = (pre_reg == STC_PRE_MAX);
         STC_CS_EXT_FALL: tick = ext_reg[1] & ~ext_reg[0];
         STC_CS_EXT_RISE: tick = ~ext_reg[1] & ext_reg[0];
      endcase
   end

   // top selection; unlisted modes run to max
   always_comb begin
      unique case (wgm)
         4'h1, 4'h5:                top = STC_TOP8;
         4'h2, 4'h6:                top = STC_TOP9;
         4'h3, 4'h7:                top = STC_TOP10;
         4'h4, 4'h9, 4'hB, 4'hF:    top = cmp_reg[0];
         4'h8, 4'hA, 4'hC, 4'hE:    top = cap_reg;
         default:                   top = STC_MAX;
      endcase
   end
   assign at_top = (cnt_reg == top) || (cnt_reg == STC_MAX);

   // capture trigger: pin or comparator, optional filter, chosen edge
   always_comb begin
      logic src;
      logic filt;
      src  = ctrl_b_reg[STC_B_ACSEL] ? comparator_i : capture_input_pin_i;
      filt = ctrl_b_reg[STC_B_NOISE] ? capf_reg[STC_NOISE_LEN-1] : capf_reg[0];
      capf_next = {capf_reg[STC_NOISE_LEN-2:0], src};
      if (!ctrl_b_reg[STC_B_NOISE] || (&capf_reg) || ~(|capf_reg))
         capl_next = filt;
      else
         capl_next = capl_reg;
      cap_trig = (capl_next != capl_reg) && (capl_next == ctrl_b_reg[STC_B_CAPEDGE]);
   end

   // per channel compare and pin qualification
   for (genvar i = 0; i < 3; i++) begin : g_chan
      assign match[i]   = (cnt_reg == cmp_reg[i]);
      assign force_c[i] = bus.wr && (bus.addr == STC_CTRL_C) && bus.wdata[STC_C_FOCA-i];
      // legacy hides channel c; compare-a top in modes B and F kills output a
      assign chan_ok[i] = !(i == 2 && legacy_mode_i)
                       && !(i == 0 && (wgm == 4'hB || wgm == 4'hF));
   end

   // ============================================================
   // next state: bus, counter, flags
   always_comb begin
      logic [4:0] ev;
      logic       in_pwm;
      ctrl_a_next = ctrl_a_reg;
      ctrl_b_next = ctrl_b_reg;
      hold_next   = hold_reg;
      rdata_next  = 8'h00;
      cnt_next    = cnt_reg;
      cap_next    = cap_reg;
      mask_next   = mask_reg;
      wave_next   = wave_reg;
      pre_next    = pre_reg + 10'h001;                                // free running
      ext_next    = {ext_reg[0], external_clock_pin_i};
      ev          = 5'h00;
      in_pwm      = (wgm != 4'h0) && (wgm != 4'h4) && (wgm != 4'hC);
      for (int i = 0; i < 3; i++) begin
         cmp_next[i]    = cmp_reg[i];
         cmpbuf_next[i] = cmpbuf_reg[i];
      end
      // counter: wrap at top, then cpu write overrides
      if (tick)
         cnt_next = at_top ? STC_BOTTOM : cnt_reg + 16'h0001;
      if (tick && at_top)
         ev[STC_FLG_OVF] = 1'b1;
      if (cap_trig) begin
         cap_next = cnt_reg;
         ev[STC_FLG_CAP] = 1'b1;
      end
      // buffered compares update at top in pwm modes
      for (int i = 0; i < 3; i++) begin
         if (!in_pwm || (tick && at_top))
            cmp_next[i] = cmpbuf_reg[i];
         if ((tick && match[i]) || force_c[i]) begin
            if (chan_ok[i])
               wave_next[i] = ~wave_reg[i];
            // a compare-a top still flags its match; only legacy hides c
            if (!force_c[i] && !(i == 2 && legacy_mode_i))
               ev[STC_FLG_CMPA + i] = 1'b1;
         end
      end
      if (bus.wr) begin
         unique case (bus.addr)
            STC_CTRL_A: ctrl_a_next = bus.wdata;
            STC_CTRL_B: ctrl_b_next = bus.wdata;
            STC_MASK:   mask_next   = bus.wdata[4:0];
            STC_CNT_H, STC_CMPA_H, STC_CMPB_H, STC_CMPC_H, STC_CAP_H:
               hold_next = bus.wdata;
            STC_CNT_L:  cnt_next = {hold_reg, bus.wdata};
            STC_CMPA_L: cmpbuf_next[0] = {hold_reg, bus.wdata};
            STC_CMPB_L: cmpbuf_next[1] = {hold_reg, bus.wdata};
            STC_CMPC_L: cmpbuf_next[2] = {hold_reg, bus.wdata};
            STC_CAP_L:  cap_next = {hold_reg, bus.wdata};
            default: ;
         endcase
      end
      if (bus.rd) begin
         unique case (bus.addr)
            STC_CTRL_A: rdata_next = ctrl_a_reg;
            STC_CTRL_B: rdata_next = ctrl_b_reg;
            STC_FLAGS:  rdata_next = {3'h0, flag_reg};
            STC_MASK:   rdata_next = {3'h0, mask_reg};
            STC_CNT_L: begin
               rdata_next = cnt_reg[7:0];
               hold_next  = cnt_reg[15:8];
            end
            STC_CAP_L: begin
               rdata_next = cap_reg[7:0];
               hold_next  = cap_reg[15:8];
            end
            STC_CNT_H, STC_CAP_H: rdata_next = hold_reg;
            STC_CMPA_L: rdata_next = cmpbuf_reg[0][7:0];
            STC_CMPA_H: rdata_next = cmpbuf_reg[0][15:8];
            STC_CMPB_L: rdata_next = cmpbuf_reg[1][7:0];
            STC_CMPB_H: rdata_next = cmpbuf_reg[1][15:8];
            STC_CMPC_L: rdata_next = cmpbuf_reg[2][7:0];
            STC_CMPC_H: rdata_next = cmpbuf_reg[2][15:8];
            default:    rdata_next = 8'h00;
         endcase
      end
      // write one to clear; a new event wins over the clear
      flag_next = flag_reg;
      if (bus.wr && bus.addr == STC_FLAGS)
         flag_next = flag_reg & ~bus.wdata[4:0];
      flag_next = flag_next | ev;
      if (legacy_mode_i)
         mask_next[STC_FLG_CMPC] = 1'b0;
      irq_next = |(flag_next & mask_next);
   end

   // ============================================================
   // registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_a_reg <= STC_CTRL_RST;
         ctrl_b_reg <= STC_CTRL_RST;
         hold_reg   <= 8'h00;
         rdata_reg  <= 8'h00;
         cnt_reg    <= STC_BOTTOM;
         cap_reg    <= STC_BOTTOM;
         flag_reg   <= 5'h00;
         mask_reg   <= 5'h00;
         wave_reg   <= 3'h0;
         pre_reg    <= 10'h000;
         ext_reg    <= 2'h0;
         capf_reg   <= '0;
         capl_reg   <= 1'b0;
         irq_reg    <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            cmp_reg[i]    <= STC_BOTTOM;
            cmpbuf_reg[i] <= STC_BOTTOM;
         end
      end else begin
         ctrl_a_reg <= ctrl_a_next;
         ctrl_b_reg <= ctrl_b_next;
         hold_reg   <= hold_next;
         rdata_reg  <= rdata_next;
         cnt_reg    <= cnt_next;
         cap_reg    <= cap_next;
         flag_reg   <= flag_next;
         mask_reg   <= mask_next;
         wave_reg   <= wave_next;
         pre_reg    <= pre_next;
         ext_reg    <= ext_next;
         capf_reg   <= capf_next;
         capl_reg   <= capl_next;
         irq_reg    <= irq_next;
         for (int i = 0; i < 3; i++) begin
            cmp_reg[i]    <= cmp_next[i];
            cmpbuf_reg[i] <= cmpbuf_next[i];
         end
      end
   end

   assign reg_rdata_o         = rdata_reg;
   assign waveform_output_a_o = wave_reg[0];
   assign waveform_output_b_o = wave_reg[1];
   assign waveform_output_c_o = wave_reg[2];
   assign irq_o               = irq_reg;

   // ============================================================
   // checks
   sequence s_lo_write;
      bus.wr && bus.addr == STC_CNT_L;
   endsequence

   AST_CNT_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_lo_write |=> cnt_reg == {$past(hold_reg), $past(bus.wdata)})
      else $error("counter low write did not load both bytes");
   AST_HI_ONLY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (bus.wr && bus.addr == STC_CNT_H && cs == STC_CS_OFF) |=> $stable(cnt_reg))
      else $error("high byte write changed counter");
   AST_RD_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (bus.rd && bus.addr == STC_CNT_L && !bus.wr) |=> hold_reg == $past(cnt_reg[15:8]))
      else $error("low read did not latch high byte");
   AST_CMP_RD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (bus.rd && bus.addr == STC_CMPB_L) |=> $stable(hold_reg))
      else $error("compare read touched holding register");
   AST_STOPPED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cs == STC_CS_OFF && !bus.wr) |=> $stable(cnt_reg))
      else $error("counter moved with no clock");
   AST_DIV8: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cs == STC_CS_DIV8 && tick) |=> !tick [*7])
      else $error("divide by eight ticked early");
   AST_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tick && match[1] && chan_ok[1]) |=> flag_reg[STC_FLG_CMPB])
      else $error("compare b flag not set");
   AST_CAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cap_trig && !(bus.wr && bus.addr == STC_CAP_L)) |=> cap_reg == $past(cnt_reg))
      else $error("capture missed counter");
   AST_LEGACY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      legacy_mode_i |=> $stable(waveform_output_c_o) && !$rose(flag_reg[STC_FLG_CMPC])
                        && !mask_reg[STC_FLG_CMPC])
      else $error("channel c active in legacy mode");

   // ============================================================
   // step-wise checks built from named sequences
   sequence s_cmpa_hi_write;
      bus.wr && bus.addr == STC_CMPA_H;
   endsequence
   sequence s_cmpa_lo_write;
      bus.wr && bus.addr == STC_CMPA_L;
   endsequence
   // rising pin edge seen by the detector, no cpu write in the way
   sequence s_ext_rise;
      cs == STC_CS_EXT_RISE && !ext_reg[1] && ext_reg[0] && !bus.wr;
   endsequence

   AST_HOLD_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_cmpa_hi_write |=> hold_reg == $past(bus.wdata) && $stable(cmpbuf_reg[0]))
      else $error("high byte write reached compare buffer");
   AST_CMPA_WRITE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_cmpa_lo_write |=> cmpbuf_reg[0] == {$past(hold_reg), $past(bus.wdata)})
      else $error("compare low write did not load both bytes");
   AST_TOP_WRAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tick && at_top && !bus.wr) |=> cnt_reg == STC_BOTTOM)
      else $error("counter did not wrap at top");
   AST_PWM_BUF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (ctrl_a_reg[1:0] != 2'h0 && !(tick && at_top)) |=> $stable(cmp_reg[0]))
      else $error("pwm compare a moved away from top");
   AST_NO_OUT_A: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wgm == 4'hF) |=> $stable(waveform_output_a_o))
      else $error("output a moved with compare a as top");
   AST_EXT_RISE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      s_ext_rise |=> cnt_reg == $past(cnt_reg) + 16'h0001 || cnt_reg == STC_BOTTOM)
      else $error("pin rising edge did not count");
   AST_CAP_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cap_trig |=> flag_reg[STC_FLG_CAP])
      else $error("capture did not set its flag");
   // request line must agree with flags and mask at every edge
   AST_IRQ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      irq_o == |(flag_reg & mask_reg))
      else $error("request line disagrees with flags and mask");
endmodule : stc_timer

/* testbench/stc_cpu_model.sv */
// Purpose: processor side of the byte-wide timer register port
// Assumes: no wait states, read data stands only in the cycle after the strobe
// Notes: 16-bit helpers keep the high-first write and low-first read order
module stc_cpu_model
   import stc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [4:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // idle bus from time zero
   initial begin
      addr_o  = 5'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // ==========================================
   // single byte cycles, strobes one cycle long
   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
   endtask : wr8
   task automatic rd8(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      @(posedge clk_i);
      d = rdata_i;        // taken before the edge updates land
   endtask : rd8
   // ==========================================
   // pairs: other order would commit a stale holding byte
   task automatic wr16(input logic [4:0] a, input logic [15:0] v);
      wr8(a + 5'h01, v[15:8]);
      wr8(a, v[7:0]);
   endtask : wr16
   task automatic rd16(input logic [4:0] a, output logic [15:0] v);
      rd8(a, v[7:0]);
      rd8(a + 5'h01, v[15:8]);
   endtask : rd16
endmodule : stc_cpu_model

/* testbench/tb.sv */
// Purpose: self-checking bench for the timer core register path and events
// Assumes: 100 MHz clock, counter stopped while registers are set up
// Notes: prescaled counts are judged within a small tolerance window
module tb
   import stc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_i, sys_rst_i, legacy, ext_pin, cap_pin, comp_in;
   logic       wr, rd, wav_a, wav_b, wav_c, irq;
   logic [4:0] addr;
   logic [7:0] wdata, rdata;
   int         bad_count, n_checks;
   stc_timer stc_timer_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .legacy_mode_i(legacy),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .external_clock_pin_i(ext_pin), .capture_input_pin_i(cap_pin),
      .comparator_i(comp_in), .waveform_output_a_o(wav_a), .waveform_output_b_o(wav_b),
      .waveform_output_c_o(wav_c), .irq_o(irq));
   stc_cpu_model stc_cpu_model_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   // ==========================================
   // helpers
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic w8(input logic [4:0] a, input logic [7:0] d);
      stc_cpu_model_i.wr8(a, d);
   endtask : w8
   task automatic w16(input logic [4:0] a, input logic [15:0] v);
      stc_cpu_model_i.wr16(a, v);
   endtask : w16
   task automatic c8(input string n, input logic [4:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      logic [7:0] d;
      stc_cpu_model_i.rd8(a, d);
      chk(n, {8'h00, e}, {8'h00, d & m});
   endtask : c8
   task automatic c16(input string n, input logic [4:0] a, input logic [15:0] e);
      logic [15:0] v;
      stc_cpu_model_i.rd16(a, v);
      chk(n, e, v);
   endtask : c16
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   // ==========================================
   // scenarios
   task automatic t_access;
      c8("ctrl_b_rst", STC_CTRL_B, 8'hFF, 8'h00);
      chk("irq_rst", 16'h0000, {15'h0000, irq});
      w16(STC_CMPA_L, 16'h1234);
      w16(STC_CNT_L, 16'hABCD);
      c8("cnt_lo", STC_CNT_L, 8'hFF, 8'hCD);
      c8("cmpa_hi", STC_CMPA_H, 8'hFF, 8'h12);
      c8("cnt_hi", STC_CNT_H, 8'hFF, 8'hAB);
      w8(STC_CNT_L, 8'h00);
      c16("cnt_reuse", STC_CNT_L, 16'hAB00);
      w8(STC_CNT_H, 8'h77);
      c16("cnt_hi_only", STC_CNT_L, 16'hAB00);
   endtask : t_access
   // wraps past max, then meets compare a
   task automatic t_match;
      w8(STC_FLAGS, 8'h1F);
      w16(STC_CMPA_L, 16'h0004);
      w16(STC_CNT_L, 16'hFFF8);
      w8(STC_MASK, 8'h02);
      w8(STC_CTRL_B, 8'h01);
      repeat (30) @(posedge clk_i);
      w8(STC_CTRL_B, 8'h00);
      c8("flag_ovf", STC_FLAGS, 8'h01, 8'h01);
      c8("flag_a", STC_FLAGS, 8'h02, 8'h02);
      chk("irq_a", 16'h0001, {15'h0000, irq});
      chk("pin_a", 16'h0001, {15'h0000, wav_a});
      chk("pin_b", 16'h0001, {15'h0000, wav_b});
   endtask : t_match
   // every internal code over one fixed span
   task automatic t_prescale;
      int          dv[6] = '{0, 1, 8, 64, 256, 1024};
      int          e;
      logic [15:0] v;
      for (int cs = 0; cs < 6; cs++) begin
         w16(STC_CNT_L, 16'h0000);
         w8(STC_CTRL_B, 8'(cs));
         repeat (2048) @(posedge clk_i);
         w8(STC_CTRL_B, 8'h00);
         stc_cpu_model_i.rd16(STC_CNT_L, v);
         e = (cs == 0) ? 0 : 2050 / dv[cs];
         n_checks++;
         if ((v + 16'd2 >= 16'(e) && v <= 16'(e + 2)) !== 1'b1) begin
            bad_count++;
            $display("[ERR] count code %0d expected %0d seen %h", cs, e, v);
         end
      end
   endtask : t_prescale
   // five pin pulses, rising then falling edge codes
   task automatic t_ext;
      for (int k = 0; k < 2; k++) begin
         w16(STC_CNT_L, 16'h0000);
         w8(STC_CTRL_B, (k == 0) ? 8'h07 : 8'h06);
         repeat (5) begin
            @(posedge clk_i) ext_pin <= 1'b1;
            repeat (3) @(posedge clk_i);
            ext_pin <= 1'b0;
            repeat (3) @(posedge clk_i);
         end
         repeat (6) @(posedge clk_i);
         w8(STC_CTRL_B, 8'h00);
         c16("ext_count", STC_CNT_L, 16'h0005);
      end
   endtask : t_ext
   // channel c present, then hidden
   task automatic t_chan_c;
      logic w0;
      for (int lg = 0; lg < 2; lg++) begin
         @(posedge clk_i) legacy <= 1'(lg);
         w8(STC_FLAGS, 8'h1F);
         w16(STC_CMPC_L, 16'h0006);
         w16(STC_CNT_L, 16'h0000);
         w8(STC_MASK, 8'h08);
         w0 = wav_c;
         w8(STC_CTRL_B, 8'h01);
         repeat (20) @(posedge clk_i);
         w8(STC_CTRL_B, 8'h00);
         c8("flag_c", STC_FLAGS, 8'h08, (lg == 0) ? 8'h08 : 8'h00);
         c8("mask_c", STC_MASK, 8'h08, (lg == 0) ? 8'h08 : 8'h00);
         chk("irq_c", {15'h0000, lg == 0}, {15'h0000, irq});
         chk("pin_c", {15'h0000, w0 ^ (lg == 0)}, {15'h0000, wav_c});
      end
      @(posedge clk_i) legacy <= 1'b0;
   endtask : t_chan_c
   task automatic t_force;
      logic w0;
      w0 = wav_a;
      w8(STC_CTRL_C, 8'h80);
      repeat (2) @(posedge clk_i);
      chk("force_a", {15'h0000, ~w0}, {15'h0000, wav_a});
      c8("ctrl_c_rd", STC_CTRL_C, 8'hFF, 8'h00);
   endtask : t_force
   // capture from pin, then from comparator
   task automatic t_capture;
      for (int s = 0; s < 2; s++) begin
         w16(STC_CNT_L, 16'h4321 + 16'(s));
         w8(STC_CTRL_B, (s == 0) ? 8'h40 : 8'h60);
         w8(STC_FLAGS, 8'h1F);
         @(posedge clk_i) if (s == 0) cap_pin <= 1'b1; else comp_in <= 1'b1;
         repeat (4) @(posedge clk_i);
         cap_pin <= 1'b0;
         comp_in <= 1'b0;
         repeat (4) @(posedge clk_i);
         c16("cap_value", STC_CAP_L, 16'h4321 + 16'(s));
         c8("flag_cap", STC_FLAGS, 8'h10, 8'h10);
      end
   endtask : t_capture
   // fixed nine-bit top, then compare a as top with output a hidden
   task automatic t_top;
      logic w0;
      w16(STC_CMPA_L, 16'h0003);
      w8(STC_FLAGS, 8'h1F);
      w8(STC_CTRL_A, 8'h02);
      w16(STC_CNT_L, 16'h01FE);
      w8(STC_CTRL_B, 8'h01);
      w8(STC_CTRL_B, 8'h00);
      c16("top_fixed", STC_CNT_L, 16'h0000);
      c8("top_ovf", STC_FLAGS, 8'h01, 8'h01);
      w8(STC_CTRL_A, 8'h03);
      c8("ctrl_a_rd", STC_CTRL_A, 8'hFF, 8'h03);
      w16(STC_CNT_L, 16'h0000);
      w8(STC_FLAGS, 8'h1F);
      w0 = wav_a;
      w8(STC_CTRL_B, 8'h19);
      repeat (10) @(posedge clk_i);
      w8(STC_CTRL_B, 8'h18);
      c8("top_cmpa", STC_CNT_L, 8'hFC, 8'h00);
      c8("flag_a_top", STC_FLAGS, 8'h02, 8'h02);
      chk("pin_a_top", {15'h0000, w0}, {15'h0000, wav_a});
      w8(STC_CTRL_B, 8'h00);
      w8(STC_CTRL_A, 8'h00);
   endtask : t_top
   // filter drops a two-cycle spike, passes a long pulse
   task automatic t_filter;
      w16(STC_CNT_L, 16'h0BAD);
      w8(STC_CTRL_B, 8'hC0);
      w8(STC_FLAGS, 8'h1F);
      for (int p = 2; p < 12; p += 8) begin
         @(posedge clk_i) cap_pin <= 1'b1;
         repeat (p) @(posedge clk_i);
         cap_pin <= 1'b0;
         repeat (8) @(posedge clk_i);
         c8("flag_filt", STC_FLAGS, 8'h10, (p > 8) ? 8'h10 : 8'h00);
      end
      c16("cap_filt", STC_CAP_L, 16'h0BAD);
      w8(STC_CTRL_B, 8'h00);
   endtask : t_filter
   // ==========================================
   // clock, reset, sequence, watchdog
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {legacy, ext_pin, cap_pin, comp_in} = 4'h0;
      bad_count = 0;
      n_checks  = 0;
      sys_rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_access();
      t_match();
      t_prescale();
      t_ext();
      t_chan_c();
      t_force();
      t_top();
      t_capture();
      t_filter();
      final_report();
   end
   // whole run is about 12.8k cycles; three and a half times that before giving up
   initial begin
      repeat (45000) @(posedge clk_i);
      bad_count++;
      final_report();
   end
endmodule : tb
